// File: include/uim_params.svh
// Offsets, field positions, reset values and counts of the interrupt block
`ifndef UIM_PARAMS_SVH
`define UIM_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define UIM_OFS_MASK   12'h038
`define UIM_OFS_RAW    12'h03c
`define UIM_OFS_MIS    12'h040
`define UIM_OFS_CLR    12'h044

// ----------------------------------------------------------------------
// Field positions, shared by mask, raw, masked and clear layouts
// ----------------------------------------------------------------------
`define UIM_B_OE       10
`define UIM_B_BE       9
`define UIM_B_PE       8
`define UIM_B_FE       7
`define UIM_B_RT       6
`define UIM_B_TX       5
`define UIM_B_RX       4
`define UIM_B_DSR      3
`define UIM_B_DCD      2
`define UIM_B_CTS      1
`define UIM_B_RI       0

// ----------------------------------------------------------------------
// Widths, reset values and counts
// ----------------------------------------------------------------------
`define UIM_SRC_N      11
`define UIM_MASK_RST   11'h000
`define UIM_RAW_RST    11'h000
`define UIM_RT_BITS    32
`define UIM_CNT_W      5

`endif

// File: include/uim_pkg.sv
// Types of the interrupt mask and raw status block
package uim_pkg;

  // Source vector, one bit per interrupt source
  typedef logic [10:0] uim_src_t;

  // Receive timeout detector states, one-hot
  typedef enum logic [2:0] {
    UIM_RT_IDLE  = 3'b001,
    UIM_RT_COUNT = 3'b010,
    UIM_RT_FIRED = 3'b100
  } uim_rt_state_e;

endpackage : uim_pkg

// File: logic/uim_sticky.sv
// Bank of sticky status bits in which a set beats a clear
`timescale 1ns/100ps

module uim_sticky #(
  parameter int W = 11
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_set,
  input  wire logic [W-1:0] i_clr,
  output logic      [W-1:0] o_q
);

  if (W < 1) begin : g_chk
    $error("uim_sticky: W must be at least 1");
  end

  logic [W-1:0] q_nxt;

  // An event landing in the clearing cycle is kept
  assign q_nxt = (o_q & ~i_clr) | i_set;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_q <= '0;
    end else begin
      o_q <= q_nxt;
    end
  end

endmodule : uim_sticky

// File: logic/uim_rx_timeout.sv
// Receive timeout detector counting bit periods of line silence
`timescale 1ns/100ps
`include "uim_params.svh"

module uim_rx_timeout #(
  parameter int BITS = `UIM_RT_BITS,
  parameter int CW   = `UIM_CNT_W
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_enable,
  input  wire logic i_nonempty,
  input  wire logic i_rx_push,
  input  wire logic i_bit_tick,
  output logic      o_fire
);

  if (BITS < 2 || BITS > (1 << CW)) begin : g_chk
    $error("uim_rx_timeout: BITS does not fit the counter");
  end

  uim_pkg::uim_rt_state_e state_r;
  uim_pkg::uim_rt_state_e state_nxt;
  logic [CW-1:0]          cnt_r;
  logic [CW-1:0]          cnt_nxt;
  logic                   last_w;
  logic                   stop_w;

  // Disabled means idle: the mask doubles as a power enable
  assign stop_w = ~i_enable | ~i_nonempty;
  assign last_w = i_bit_tick && (cnt_r == CW'(BITS - 1));

  // Any new character restarts the silence window
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      uim_pkg::UIM_RT_IDLE: begin
        cnt_nxt = '0;
        if (!stop_w) state_nxt = uim_pkg::UIM_RT_COUNT;
      end
      uim_pkg::UIM_RT_COUNT: begin
        if (stop_w) begin
          state_nxt = uim_pkg::UIM_RT_IDLE;
        end else if (i_rx_push) begin
          cnt_nxt = '0;
        end else if (last_w) begin
          state_nxt = uim_pkg::UIM_RT_FIRED;
        end else if (i_bit_tick) begin
          cnt_nxt = cnt_r + CW'(1);
        end
      end
      uim_pkg::UIM_RT_FIRED: begin
        cnt_nxt = '0;
        if (stop_w) state_nxt = uim_pkg::UIM_RT_IDLE;
        else if (i_rx_push) state_nxt = uim_pkg::UIM_RT_COUNT;
      end
      default: begin
        state_nxt = uim_pkg::UIM_RT_IDLE;
        cnt_nxt   = '0;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= uim_pkg::UIM_RT_IDLE;
      cnt_r   <= '0;
      o_fire  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      o_fire  <= (state_r == uim_pkg::UIM_RT_COUNT) && !stop_w
                 && !i_rx_push && last_w;
    end
  end

endmodule : uim_rx_timeout

// File: logic/uim_top.sv
// Serial port interrupt mask, raw status and request logic on APB
//
// Decided for this implementation: the APB register port.
`timescale 1ns/100ps
`include "uim_params.svh"

module uim_top #(
  parameter int CW      = 5,
  parameter int RT_BITS = `UIM_RT_BITS
) (
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  // APB slave
  input  wire logic          i_psel,
  input  wire logic          i_penable,
  input  wire logic          i_pwrite,
  input  wire logic [11:0]   i_paddr,
  input  wire logic [31:0]   i_pwdata,
  output logic      [31:0]   o_prdata,
  output logic               o_pready,
  output logic               o_pslverr,
  // Receive error events from the receiver
  input  wire logic          i_overrun_evt,
  input  wire logic          i_break_evt,
  input  wire logic          i_parity_evt,
  input  wire logic          i_framing_evt,
  // FIFO fill state, receive push and bit tick
  input  wire logic          i_fifo_en,
  input  wire logic [CW-1:0] i_rx_count,
  input  wire logic [CW-1:0] i_tx_count,
  input  wire logic [CW-1:0] i_rx_trig,
  input  wire logic [CW-1:0] i_tx_trig,
  input  wire logic          i_rx_push,
  input  wire logic          i_bit_tick,
  // Modem status lines
  input  wire logic          i_dsr,
  input  wire logic          i_dcd,
  input  wire logic          i_cts,
  input  wire logic          i_ri,
  // Request and timeout power enable
  output logic               o_irq,
  output logic               o_rt_enable
);

  // ----------------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------------
  if (CW < 1 || CW > 16) begin : g_chk_cw
    $error("uim_top: CW out of range");
  end
  if (RT_BITS < 2) begin : g_chk_rt
    $error("uim_top: RT_BITS too small");
  end

  localparam int RTW = $clog2(RT_BITS + 1);

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // Word-aligned address match
  function automatic logic hit(input logic [11:0] a,
                               input logic [11:0] ofs);
    hit = (a[11:2] == ofs[11:2]);
  endfunction : hit

  // True when a fill level passes upward through a threshold
  function automatic logic rises(input logic [CW-1:0] was,
                                 input logic [CW-1:0] now,
                                 input logic [CW-1:0] thr);
    rises = (was < thr) && (now >= thr);
  endfunction : rises

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  uim_pkg::uim_src_t mask_r;
  uim_pkg::uim_src_t raw_w;
  uim_pkg::uim_src_t mis_w;
  uim_pkg::uim_src_t set_w;
  uim_pkg::uim_src_t clr_w;
  uim_pkg::uim_src_t icr_w;
  logic [CW-1:0]     rx_cnt_r;
  logic [CW-1:0]     tx_cnt_r;
  logic [CW-1:0]     rx_thr_w;
  logic [CW-1:0]     tx_thr_w;
  logic              rx_up_w;
  logic              rx_below_w;
  logic              tx_down_w;
  logic              tx_above_w;
  logic              rx_empty_w;
  logic              rt_fire_w;
  logic [3:0]        modem_r;
  logic [3:0]        modem_now_w;
  logic [3:0]        modem_chg_w;
  logic              modem_vld_r;
  logic              acc_w;
  logic              done_w;
  logic              pready_nxt;
  logic              wr_w;
  logic              hit_mask_w;
  logic              hit_raw_w;
  logic              hit_mis_w;
  logic              hit_clr_w;
  logic              mapped_w;
  logic [31:0]       rd_mux_w;
  logic [31:0]       prdata_nxt;
  logic              pslverr_nxt;
  logic              irq_nxt;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  // Every access waits one cycle, so pready is a plain flop
  assign acc_w       = i_psel & i_penable;
  assign done_w      = acc_w & o_pready;
  assign pready_nxt  = acc_w & ~o_pready;
  assign wr_w        = done_w & i_pwrite;

  assign hit_mask_w  = hit(i_paddr, `UIM_OFS_MASK);
  assign hit_raw_w   = hit(i_paddr, `UIM_OFS_RAW);
  assign hit_mis_w   = hit(i_paddr, `UIM_OFS_MIS);
  assign hit_clr_w   = hit(i_paddr, `UIM_OFS_CLR);
  assign mapped_w    = hit_mask_w | hit_raw_w | hit_mis_w | hit_clr_w;

  // Reads zero-extend the 11 live bits; clear reads as zero
  assign rd_mux_w =
      hit_mask_w ? {21'h000000, mask_r} :
      hit_raw_w  ? {21'h000000, raw_w}  :
      hit_mis_w  ? {21'h000000, mis_w}  :
                   32'h00000000;

  assign prdata_nxt  = (pready_nxt & ~i_pwrite) ? rd_mux_w
                                                : 32'h00000000;
  assign pslverr_nxt = pready_nxt & ~mapped_w;

  // Write-one-to-clear strobes, only at the completing edge
  assign icr_w = (wr_w & hit_clr_w) ? i_pwdata[10:0] : '0;

  // ----------------------------------------------------------------------
  // Bus answer registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h00000000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= pready_nxt;
      o_prdata  <= prdata_nxt;
      o_pslverr <= pslverr_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Mask register
  // ----------------------------------------------------------------------
  // Upper bits are dropped on write, so they can never read back
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mask_r <= `UIM_MASK_RST;
    end else if (wr_w && hit_mask_w) begin
      mask_r <= i_pwdata[10:0];
    end
  end

  // Timeout detector power enable follows its mask bit
  assign o_rt_enable = mask_r[`UIM_B_RT];

  // ----------------------------------------------------------------------
  // FIFO level crossings
  // ----------------------------------------------------------------------
  // Without FIFOs the receive threshold is one and the transmit threshold zero
  assign rx_thr_w   = i_fifo_en ? i_rx_trig : CW'(1);
  assign tx_thr_w   = i_fifo_en ? i_tx_trig : '0;

  // Transitions, not levels, set the flags
  assign rx_up_w    = rises(rx_cnt_r, i_rx_count, rx_thr_w);
  assign rx_below_w = (i_rx_count < rx_thr_w);
  assign tx_down_w  = (tx_cnt_r > tx_thr_w) &&
                      (i_tx_count <= tx_thr_w);
  assign tx_above_w = (i_tx_count > tx_thr_w);
  assign rx_empty_w = (i_rx_count == '0);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_cnt_r <= '0;
      tx_cnt_r <= '0;
    end else begin
      rx_cnt_r <= i_rx_count;
      tx_cnt_r <= i_tx_count;
    end
  end

  // ----------------------------------------------------------------------
  // Modem line change detect
  // ----------------------------------------------------------------------
  assign modem_now_w = {i_dsr, i_dcd, i_cts, i_ri};
  // First sample after reset only primes the history
  assign modem_chg_w = modem_vld_r ? (modem_now_w ^ modem_r) : 4'h0;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      modem_r     <= 4'h0;
      modem_vld_r <= 1'b0;
    end else begin
      modem_r     <= modem_now_w;
      modem_vld_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Receive timeout
  // ----------------------------------------------------------------------
  // Masked off, the detector idles and draws no switching power
  uim_rx_timeout #(
    .BITS       (RT_BITS),
    .CW         (RTW)
  ) u_rt (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_enable   (mask_r[`UIM_B_RT]),
    .i_nonempty (~rx_empty_w),
    .i_rx_push  (i_rx_push),
    .i_bit_tick (i_bit_tick),
    .o_fire     (rt_fire_w)
  );

  // ----------------------------------------------------------------------
  // Set and clear vectors
  // ----------------------------------------------------------------------
  // Error flags ignore the mask entirely
  always_comb begin
    set_w = '0;
    set_w[`UIM_B_OE]  = i_overrun_evt;
    set_w[`UIM_B_BE]  = i_break_evt;
    set_w[`UIM_B_PE]  = i_parity_evt;
    set_w[`UIM_B_FE]  = i_framing_evt;
    set_w[`UIM_B_RT]  = rt_fire_w &
                        mask_r[`UIM_B_RT];
    set_w[`UIM_B_TX]  = tx_down_w;
    set_w[`UIM_B_RX]  = rx_up_w;
    set_w[`UIM_B_DSR] = modem_chg_w[3];
    set_w[`UIM_B_DCD] = modem_chg_w[2];
    set_w[`UIM_B_CTS] = modem_chg_w[1];
    set_w[`UIM_B_RI]  = modem_chg_w[0];
  end

  // Software clears any bit; hardware also drops level-type flags
  always_comb begin
    clr_w = icr_w;
    clr_w[`UIM_B_RT] = icr_w[`UIM_B_RT] | rx_empty_w |
                       ~mask_r[`UIM_B_RT];
    clr_w[`UIM_B_TX] = icr_w[`UIM_B_TX] | tx_above_w;
    clr_w[`UIM_B_RX] = icr_w[`UIM_B_RX] | rx_below_w;
  end

  // ----------------------------------------------------------------------
  // Raw status bank
  // ----------------------------------------------------------------------
  // Set wins over a clear in the same cycle, so no event is lost
  uim_sticky #(
    .W      (`UIM_SRC_N)
  ) u_raw (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_set  (set_w),
    .i_clr  (clr_w),
    .o_q    (raw_w)
  );

  // ----------------------------------------------------------------------
  // Masked status and request
  // ----------------------------------------------------------------------
  assign mis_w   = raw_w & mask_r;
  assign irq_nxt = |mis_w;

  // Registered request lags the raw bit by one cycle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= irq_nxt;
    end
  end

endmodule : uim_top

// File: testbench/uim_props.sv
// Checker of bus timing, mask readback and request of the interrupt block
`timescale 1ns/100ps
`include "uim_params.svh"

module uim_props (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        i_overrun_evt,
  input wire logic        i_break_evt,
  input wire logic        i_parity_evt,
  input wire logic        i_framing_evt,
  input wire logic        i_dsr,
  input wire logic        i_dcd,
  input wire logic        i_cts,
  input wire logic        i_ri,
  input wire logic        o_irq,
  input wire logic        o_rt_enable
);
  // ----------------------------------------------------------------
  // Shadow of the mask, updated only by completed writes
  // ----------------------------------------------------------------
  wire [11:0] wa      = i_paddr & 12'hffc;
  wire        done    = i_psel & i_penable & o_pready;
  wire        rd_done = done & ~i_pwrite;
  wire        wr_mask = done & i_pwrite & (wa == `UIM_OFS_MASK);
  wire [10:0] evt_v   = {i_overrun_evt, i_break_evt, i_parity_evt,
                         i_framing_evt, 7'h00};
  logic [10:0] mask_r;

  // Shadow register of the enables
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) mask_r <= 11'h000;
    else if (wr_mask) mask_r <= i_pwdata[10:0];
  end

  default clocking dclk @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // Request follows one cycle behind the sticky bit
  sequence s_req_up;
    ##2 o_irq;
  endsequence
  sequence s_access_go;
    i_psel && $rose(i_penable);
  endsequence

  ready_after_a: assert property (s_access_go |=> o_pready)
    else $error("ready missing after access start");
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("ready held longer than one cycle");
  err_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  upper_zero_a: assert property (o_pready |-> o_prdata[31:11] == 21'h0)
    else $error("upper read bits not zero");
  mask_back_a: assert property (rd_done && wa == `UIM_OFS_MASK
    |-> o_prdata[10:0] == mask_r) else $error("mask readback wrong");
  event_irq_a: assert property ((|(evt_v & mask_r)) |-> s_req_up)
    else $error("enabled error event gave no request");
  modem_irq_a: assert property ((|(({i_dsr, i_dcd, i_cts, i_ri}
    ^ $past({i_dsr, i_dcd, i_cts, i_ri})) & mask_r[3:0])) |-> s_req_up)
    else $error("enabled modem change gave no request");
  irq_quiet_a: assert property (mask_r == 11'h0 && $past(mask_r) == 11'h0
    |-> !o_irq) else $error("request while all masked");
  rt_power_a: assert property ($stable(mask_r[6])
    |-> o_rt_enable == mask_r[6]) else $error("timeout enable wrong");
  rt_masked_a: assert property (rd_done && wa == `UIM_OFS_RAW
    && o_prdata[6] |-> mask_r[6]) else $error("timeout set while masked");
endmodule : uim_props

bind uim_top uim_props uim_props_inst (
  .i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_overrun_evt(i_overrun_evt), .i_break_evt(i_break_evt),
  .i_parity_evt(i_parity_evt), .i_framing_evt(i_framing_evt),
  .i_dsr(i_dsr), .i_dcd(i_dcd), .i_cts(i_cts), .i_ri(i_ri),
  .o_irq(o_irq), .o_rt_enable(o_rt_enable));

// File: testbench/uim_far_model.sv
// Model of the far serial device: error events, modem lines, bit ticks
`timescale 1ns/100ps

module uim_far_model #(
  parameter int DIV = 4
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [3:0] i_evt_cmd,
  input  wire logic [3:0] i_line_cmd,
  output logic      [3:0] o_evt,
  output logic      [3:0] o_line,
  output logic            o_tick
);
  int div_r;

  // Events last one cycle; lines hold their level until toggled again
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_evt  <= 4'h0;
      o_line <= 4'h0;
      o_tick <= 1'b0;
      div_r  <= 0;
    end else begin
      o_evt  <= i_evt_cmd;
      o_line <= o_line ^ i_line_cmd;
      o_tick <= (div_r == DIV - 1);
      div_r  <= (div_r == DIV - 1) ? 0 : div_r + 1;
    end
  end
endmodule : uim_far_model

// File: testbench/uim_top_bench.sv
// Self-checking bench of the serial port interrupt block
`timescale 1ns/100ps
`include "uim_params.svh"

module uim_top_bench;
  localparam int CW = 5;
  localparam int RT = 4;
  localparam int DIV = 4;
  localparam int WT = (RT + 2) * DIV + 8;
  localparam logic [11:0] A_BAD = 12'h050;
  typedef struct packed {
    logic        rd;
    logic        err;
    logic [31:0] data;
  } uim_note_s;

  logic          i_clk = 1'b0, i_rst = 1'b1, i_fifo_en = 1'b1;
  logic          i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [11:0]   i_paddr = 12'h000;
  logic [31:0]   i_pwdata = 32'h0, o_prdata, seed = 32'hcc4030c8;
  logic [CW-1:0] i_rx_count = 5'h00, i_tx_count = 5'h08;
  logic [CW-1:0] i_rx_trig = 5'h04, i_tx_trig = 5'h04;
  logic [3:0]    evt_cmd = 4'h0, line_cmd = 4'h0, evt, line;
  logic          i_rx_push = 1'b0, tick, o_pready, o_pslverr, o_irq, o_rt_en;
  uim_note_s     notes[$];
  uim_note_s     note;
  int            num_errors = 0, checked = 0, cycles = 0;

  uim_far_model #(.DIV(DIV)) uim_far_model_inst (.i_clk(i_clk),
    .i_rst(i_rst), .i_evt_cmd(evt_cmd), .i_line_cmd(line_cmd),
    .o_evt(evt), .o_line(line), .o_tick(tick));

  uim_top #(.CW(CW), .RT_BITS(RT)) uim_top_inst (.i_clk(i_clk),
    .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_overrun_evt(evt[3]), .i_break_evt(evt[2]),
    .i_parity_evt(evt[1]), .i_framing_evt(evt[0]),
    .i_fifo_en(i_fifo_en), .i_rx_count(i_rx_count),
    .i_tx_count(i_tx_count), .i_rx_trig(i_rx_trig),
    .i_tx_trig(i_tx_trig), .i_rx_push(i_rx_push), .i_bit_tick(tick),
    .i_dsr(line[3]), .i_dcd(line[2]), .i_cts(line[1]), .i_ri(line[0]),
    .o_irq(o_irq), .o_rt_enable(o_rt_en));

  // ----------------------------------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------------------------------
  always #2 i_clk = ~i_clk;

  // Whole run needs under five hundred cycles; this cuts off a hang
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      test_done();
    end
  end

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task cmp(input string what, input logic [32:0] exp, input logic [32:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // Bus answers are settled by the falling edge, so look there
  always @(negedge i_clk) begin
    if (o_pready === 1'b1 && notes.size() > 0) begin
      note = notes.pop_front();
      cmp("apb", {note.err, note.rd ? note.data : 32'h0},
          {o_pslverr, note.rd ? o_prdata : 32'h0});
    end
  end

  // Entered just after a rising edge; leaves the bus held for chaining
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
           input logic err);
    notes.push_back({~wr, err, d});
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= wr;
    i_paddr   <= a;
    i_pwdata  <= wr ? (d | (rnd() & 32'hfffff800)) : rnd();
    @(posedge i_clk);
    i_penable <= 1'b1;
    @(negedge i_clk);
    // No wait count is assumed; only the run's cycle limit ends a hang
    while (o_pready !== 1'b1) begin
      @(negedge i_clk);
    end
    @(posedge i_clk);
  endtask : apb

  task idle(input int c);
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
    repeat (c) @(posedge i_clk);
  endtask : idle

  task chk_irq(input logic exp);
    idle(2);
    @(negedge i_clk);
    cmp("irq", {32'h0, exp}, {32'h0, o_irq});
    @(posedge i_clk);
  endtask : chk_irq

  task test_done();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] v;
    int          b;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    apb(0, `UIM_OFS_MASK, 32'h0, 0);
    apb(0, `UIM_OFS_RAW, 32'h0, 0);
    apb(0, A_BAD, 32'h0, 1);
    apb(1, A_BAD, 32'h7ff, 1);
    v = rnd();
    apb(1, `UIM_OFS_MASK, v & 32'h7ff, 0);
    apb(0, `UIM_OFS_MASK, v & 32'h7ff, 0);
    apb(1, `UIM_OFS_RAW, 32'h7ff, 0);
    apb(0, `UIM_OFS_RAW, 32'h0, 0);
    $display("test registers done");
    // Every error and modem source once, half of them enabled before the event
    for (int i = 0; i < 8; i++) begin
      b = (i < 4) ? 10 - i : 7 - i;
      apb(1, `UIM_OFS_MASK, (i % 2) ? 32'h1 << b : 32'h0, 0);
      idle(1);
      if (i < 4) evt_cmd[3 - i] <= 1'b1;
      else line_cmd[7 - i] <= 1'b1;
      @(posedge i_clk);
      evt_cmd  <= 4'h0;
      line_cmd <= 4'h0;
      idle(3);
      apb(0, `UIM_OFS_RAW, 32'h1 << b, 0);
      chk_irq(i % 2);
      apb(1, `UIM_OFS_MASK, 32'h1 << b, 0);
      chk_irq(1);
      apb(1, `UIM_OFS_CLR, 32'h1 << b, 0);
      chk_irq(0);
      apb(0, `UIM_OFS_RAW, 32'h0, 0);
    end
    apb(1, `UIM_OFS_MASK, 32'h0, 0);
    $display("test events done");
    // Fill levels crossing their thresholds both ways
    i_rx_count <= 5'h03;
    idle(2);
    i_rx_count <= 5'h04;
    idle(3);
    apb(0, `UIM_OFS_RAW, 32'h10, 0);
    i_rx_count <= 5'h02;
    idle(3);
    apb(0, `UIM_OFS_RAW, 32'h0, 0);
    i_tx_count <= 5'h04;
    idle(3);
    apb(0, `UIM_OFS_RAW, 32'h20, 0);
    i_tx_count <= 5'h05;
    i_rx_count <= 5'h00;
    i_fifo_en  <= 1'b0;
    idle(3);
    apb(0, `UIM_OFS_RAW, 32'h0, 0);
    i_rx_count <= 5'h01;
    idle(3);
    apb(0, `UIM_OFS_RAW, 32'h10, 0);
    i_rx_count <= 5'h00;
    i_fifo_en  <= 1'b1;
    idle(3);
    $display("test levels done");
    // Timeout: held off while masked, cleared by emptying or by a one
    i_rx_count <= 5'h01;
    idle(WT);
    apb(0, `UIM_OFS_RAW, 32'h0, 0);
    apb(1, `UIM_OFS_MASK, 32'h40, 0);
    idle(WT);
    apb(0, `UIM_OFS_RAW, 32'h40, 0);
    chk_irq(1);
    i_rx_count <= 5'h00;
    idle(3);
    apb(0, `UIM_OFS_RAW, 32'h0, 0);
    i_rx_count <= 5'h01;
    idle(WT);
    apb(0, `UIM_OFS_RAW, 32'h40, 0);
    apb(1, `UIM_OFS_CLR, 32'h40, 0);
    apb(0, `UIM_OFS_RAW, 32'h0, 0);
    idle(WT);
    apb(1, `UIM_OFS_MASK, 32'h0, 0);
    apb(0, `UIM_OFS_RAW, 32'h0, 0);
    i_rx_count <= 5'h00;
    idle(4);
    $display("test timeout done");
    test_done();
  end
endmodule : uim_top_bench
